/* hw/mrc_defines.svh */
`ifndef MRC_DEFINES_SVH
`define MRC_DEFINES_SVH
// register offsets (byte addresses)
`define MRC_OFF_CTRL 12'h000
`define MRC_OFF_STAT 12'h004
`define MRC_OFF_IRQS 12'h008
`define MRC_OFF_IRQM 12'h00c
`define MRC_OFF_SOFT 12'h010
// ctrl fields
`define MRC_CTRL_PINEN 0
`define MRC_CTRL_LVREN 1
`define MRC_CTRL_CLKLO 2
`define MRC_CTRL_CLKHI 3
`define MRC_CTRL_LVTLO 4
`define MRC_CTRL_LVTHI 5
`define MRC_CTRL_RST 32'h0000_0003
// irq status bits
`define MRC_IRQ_PIN 0
`define MRC_IRQ_LVR 1
`define MRC_IRQ_WDN 2
`define MRC_IRQ_WDS 3
`define MRC_IRQ_W 4
// timing
`define MRC_CLK_MHZ 100
`define MRC_RSTD_MS 100
`define MRC_RSTD_CYC (`MRC_RSTD_MS * 1000 * `MRC_CLK_MHZ)
`define MRC_LVQ_US 120
`define MRC_LVQ_CYC (`MRC_LVQ_US * `MRC_CLK_MHZ)
`define MRC_SST_RC 16
`define MRC_SST_XT 1024
`define MRC_SST_LRC 2
// reset values
`define MRC_PORT_RST 8'hff
`define MRC_PC_RST 16'h0000
`define MRC_SP_TOP 3'h7
`define MRC_CNT_W 24
`endif

/* hw/mrc_pkg.sv */
package mrc_pkg;
    typedef enum {
        MRC_S_HOLD,
        MRC_S_DELAY,
        MRC_S_RUN
    } mrc_state_t;
    typedef enum logic [1:0] {
        MRC_CK_FAST_INTERNAL_RC,
        MRC_CK_ERC,
        MRC_CK_HXT,
        MRC_CK_SLOW_INTERNAL_RC
    } mrc_clksel_t;
endpackage : mrc_pkg

/* hw/mrc_qualify.sv */
`include "mrc_defines.svh"
// synchronises a level and reports it once it has held for LIMIT cycles
module mrc_qualify import mrc_pkg::*; #(
    parameter int LIMIT = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic raw_in,
    input wire logic enable,
    output logic qualified
);
    logic sync1_reg;
    logic sync2_reg;
    logic [`MRC_CNT_W-1:0] cnt_reg;
    wire logic at_limit = (cnt_reg >= `MRC_CNT_W'(LIMIT));
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end
    // short episodes restart the count and are ignored
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else if (!(enable && sync2_reg)) begin
            cnt_reg <= '0;
        end else if (!at_limit) begin
            cnt_reg <= cnt_reg + `MRC_CNT_W'(1);
        end
    end
    assign qualified = at_limit;
endmodule : mrc_qualify

/* hw/mrc_reset_ctrl.sv */
`include "mrc_defines.svh"
module mrc_reset_ctrl import mrc_pkg::*; #(
    parameter int RSTD_CYC = `MRC_RSTD_CYC,
    parameter int LVQ_CYC = `MRC_LVQ_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_reset_pin_n,
    output logic shared_port_bit_in,
    input wire logic supply_low,
    input wire logic wdt_timeout,
    input wire logic sleep_or_idle,
    output logic core_reset,
    output logic pc_clear,
    output logic sp_to_top,
    output logic ports_preset,
    output logic irq_disable,
    output logic timers_off,
    output logic wdt_clear,
    output logic wdt_timeout_flag,
    output logic power_down_flag,
    output logic irq
);
    mrc_state_t state_reg, state_next;
    logic [31:0] ctrl_reg;
    logic [`MRC_IRQ_W-1:0] irqs_reg, irqm_reg;
    logic [`MRC_CNT_W-1:0] dly_reg, dly_next;
    logic pin_s1_reg, pin_s2_reg;
    logic [1:0] wds_reg;
    logic to_reg, pdf_reg;
    logic [11:0] aaddr_reg;
    logic awr_reg, apend_reg;
    logic core_reset_reg, pc_clear_reg, sp_reg, ports_reg, wdtc_reg;
    logic portbit_reg, irq_reg;
    logic [31:0] hrdata_reg;
    logic lvr_ok;
    logic pin_mode;
    logic [1:0] clk_sel;
    assign pin_mode = ctrl_reg[`MRC_CTRL_PINEN];
    assign clk_sel = ctrl_reg[`MRC_CTRL_CLKHI:`MRC_CTRL_CLKLO];

    // pin synchroniser; the first stage feeds only the second
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
        end else begin
            pin_s1_reg <= ext_reset_pin_n;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    mrc_qualify #(.LIMIT(LVQ_CYC)) u_lvq (
        .clock(clock),
        .sys_rst(sys_rst),
        .raw_in(supply_low),
        .enable(ctrl_reg[`MRC_CTRL_LVREN]),
        .qualified(lvr_ok)
    );

    function automatic logic [`MRC_CNT_W-1:0] sst_count(input logic [1:0] sel);
        case (mrc_clksel_t'(sel))
            MRC_CK_HXT: sst_count = `MRC_CNT_W'(`MRC_SST_XT);
            MRC_CK_SLOW_INTERNAL_RC: sst_count = `MRC_CNT_W'(`MRC_SST_LRC);
            default: sst_count = `MRC_CNT_W'(`MRC_SST_RC);
        endcase
    endfunction : sst_count

    wire logic pin_rst = pin_mode && !pin_s2_reg;
    wire logic wdt_n = wdt_timeout && !sleep_or_idle;
    wire logic wdt_s = wdt_timeout && sleep_or_idle;
    wire logic full_src = pin_rst || lvr_ok || wdt_n;
    wire logic [`MRC_CNT_W-1:0] rstd = `MRC_CNT_W'(RSTD_CYC);

    // full resets hold the core; delay runs only after all sources drop
    always_comb begin
        state_next = state_reg;
        dly_next = dly_reg;
        case (state_reg)
            MRC_S_HOLD: begin
                dly_next = '0;
                if (!pin_rst && !lvr_ok) begin
                    state_next = MRC_S_DELAY;
                end
            end
            MRC_S_DELAY: begin
                if (full_src) begin
                    state_next = MRC_S_HOLD;
                end else if (dly_reg >= rstd - `MRC_CNT_W'(1)) begin
                    state_next = MRC_S_RUN;
                end else begin
                    dly_next = dly_reg + `MRC_CNT_W'(1);
                end
            end
            MRC_S_RUN: begin
                if (full_src) begin
                    state_next = MRC_S_HOLD;
                end else if (wds_reg != 2'b00) begin
                    // sleep wake: short start-up timer, no full reset
                    if (dly_reg >= sst_count(clk_sel) - `MRC_CNT_W'(1)) begin
                        dly_next = '0;
                    end else begin
                        dly_next = dly_reg + `MRC_CNT_W'(1);
                    end
                end else if (wdt_s) begin
                    dly_next = '0;
                end
            end
            default: state_next = MRC_S_HOLD;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= MRC_S_HOLD;
            dly_reg <= '0;
        end else begin
            state_reg <= state_next;
            dly_reg <= dly_next;
        end
    end

    // wds_reg: 01 = start-up timer running after sleep time-out
    wire logic sst_done = (wds_reg != 2'b00) && (dly_reg >= sst_count(clk_sel) - `MRC_CNT_W'(1));
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wds_reg <= 2'b00;
        end else if (state_reg != MRC_S_RUN || full_src || sst_done) begin
            wds_reg <= 2'b00;
        end else if (wdt_s) begin
            wds_reg <= 2'b01;
        end
    end

    wire logic hold = (state_next != MRC_S_RUN);

    // asynchronous assertion via sys_rst, release on the clock after delay
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            core_reset_reg <= 1'b1;
            pc_clear_reg <= 1'b1;
            sp_reg <= 1'b1;
            ports_reg <= 1'b1;
            wdtc_reg <= 1'b1;
        end else begin
            core_reset_reg <= hold || (wds_reg != 2'b00) || wdt_s;
            pc_clear_reg <= hold || (wds_reg != 2'b00) || wdt_s;
            sp_reg <= hold || (wds_reg != 2'b00) || wdt_s;
            ports_reg <= hold;
            wdtc_reg <= hold || wdt_s;
        end
    end

    // flags: power-on clears both; sleep time-out in the run state sets both
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            to_reg <= 1'b0;
            pdf_reg <= 1'b0;
        end else if (wdt_s && state_reg == MRC_S_RUN) begin
            to_reg <= 1'b1;
            pdf_reg <= 1'b1;
        end else if (wdt_n) begin
            to_reg <= 1'b1;
        end
    end

    // port bit reads through only when the pin is not a reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            portbit_reg <= 1'b1;
        end else begin
            portbit_reg <= pin_mode ? 1'b1 : pin_s2_reg;
        end
    end

    // ahb-lite slave, zero wait state
    wire logic acc = hsel && hready && htrans[1];
    wire logic wr_ctrl = apend_reg && awr_reg && aaddr_reg == `MRC_OFF_CTRL;
    wire logic wr_irqs = apend_reg && awr_reg && aaddr_reg == `MRC_OFF_IRQS;
    wire logic wr_irqm = apend_reg && awr_reg && aaddr_reg == `MRC_OFF_IRQM;
    wire logic [`MRC_IRQ_W-1:0] ev = {wdt_s, wdt_n, lvr_ok && state_reg == MRC_S_RUN,
                                      pin_rst && state_reg == MRC_S_RUN};
    wire logic [31:0] rd_mux =
        (haddr[11:0] == `MRC_OFF_CTRL) ? ctrl_reg :
        (haddr[11:0] == `MRC_OFF_STAT) ? {28'h0000000, 2'(state_reg), to_reg, pdf_reg} :
        (haddr[11:0] == `MRC_OFF_IRQS) ? {28'h0000000, irqs_reg} :
        (haddr[11:0] == `MRC_OFF_IRQM) ? {28'h0000000, irqm_reg} : 32'h0000_0000;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            apend_reg <= 1'b0;
            awr_reg <= 1'b0;
            aaddr_reg <= 12'h000;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            apend_reg <= acc;
            awr_reg <= hwrite;
            aaddr_reg <= haddr[11:0];
            if (acc && !hwrite) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // config survives core resets; only the power-on reset restores it
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= `MRC_CTRL_RST;
            irqm_reg <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= {26'h0000000, hwdata[5:0]};
            end
            if (wr_irqm) begin
                irqm_reg <= hwdata[`MRC_IRQ_W-1:0];
            end
        end
    end

    // set wins over write-one-to-clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irqs_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            irqs_reg <= (irqs_reg & ~(wr_irqs ? hwdata[`MRC_IRQ_W-1:0] : '0)) | ev;
            irq_reg <= |(irqs_reg & irqm_reg);
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign core_reset = core_reset_reg;
    assign pc_clear = pc_clear_reg;
    assign sp_to_top = sp_reg;
    assign ports_preset = ports_reg;
    assign irq_disable = ports_reg;
    assign timers_off = ports_reg;
    assign wdt_clear = wdtc_reg;
    assign wdt_timeout_flag = to_reg;
    assign power_down_flag = pdf_reg;
    assign shared_port_bit_in = portbit_reg;
    assign irq = irq_reg;

    a_delay_hold: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(core_reset) && $past(ports_preset) |-> $past(state_reg == MRC_S_DELAY))
        else $error("core reset released without delay");
    a_pin_holds: assert property (@(posedge clock) disable iff (sys_rst)
        pin_rst |=> ##1 core_reset)
        else $error("pin low did not hold core");
    a_pin_masked: assert property (@(posedge clock) disable iff (sys_rst)
        !pin_mode && state_reg == MRC_S_RUN && !lvr_ok && !wdt_timeout && wds_reg == 2'b00
        |=> !ports_preset)
        else $error("pin reset acted while disabled");
    a_wdt_normal: assert property (@(posedge clock) disable iff (sys_rst)
        wdt_n |=> wdt_timeout_flag ##1 ports_preset)
        else $error("normal timeout missed");
    a_wdt_sleep: assert property (@(posedge clock) disable iff (sys_rst)
        wdt_s && state_reg == MRC_S_RUN && !full_src |=> wdt_timeout_flag && power_down_flag && pc_clear)
        else $error("sleep timeout flags wrong");
    a_sleep_ports: assert property (@(posedge clock) disable iff (sys_rst)
        state_reg == MRC_S_RUN && state_next == MRC_S_RUN |=> !ports_preset)
        else $error("sleep wake touched ports");
    a_lvr_short: assert property (@(posedge clock) disable iff (sys_rst)
        !lvr_ok |-> state_next != MRC_S_HOLD || state_reg == MRC_S_HOLD || pin_rst || wdt_n)
        else $error("unqualified low voltage reset");
    a_pdf_keep: assert property (@(posedge clock) disable iff (sys_rst)
        !wdt_s |=> $stable(power_down_flag))
        else $error("power down flag changed");
    a_sp_top: assert property (@(posedge clock) disable iff (sys_rst)
        core_reset |-> sp_to_top && pc_clear)
        else $error("stack pointer not at top");
    a_irq_off: assert property (@(posedge clock) disable iff (sys_rst)
        ports_preset |-> irq_disable && timers_off && wdt_clear)
        else $error("irq or timers live during reset");
    c_pin: cover property (@(posedge clock) pin_rst ##1 !pin_rst);
    c_wdt_n: cover property (@(posedge clock) wdt_n);
    c_wdt_s: cover property (@(posedge clock) wdt_s && state_reg == MRC_S_RUN);
    c_run: cover property (@(posedge clock) $fell(core_reset));
endmodule : mrc_reset_ctrl

/* test/mrc_pin_supply_model.sv */
// pin network and supply monitor seen from outside the device
module mrc_pin_supply_model (
    input wire logic clock,
    output logic ext_reset_pin_n,
    output logic supply_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // rc network pulls the pin up whenever nothing holds it low
    initial begin
        ext_reset_pin_n = 1'b1;
        supply_low = 1'b0;
    end
    // any moment is legal, not only at start-up
    task automatic pin_low(input int n);
        @(posedge clock);
        ext_reset_pin_n <= 1'b0;
        repeat (n) @(posedge clock);
        ext_reset_pin_n <= 1'b1;
    endtask : pin_low
    // dip of n cycles; short ones must be ignored by the device
    task automatic dip(input int n);
        @(posedge clock);
        supply_low <= 1'b1;
        repeat (n) @(posedge clock);
        supply_low <= 1'b0;
    endtask : dip
endmodule : mrc_pin_supply_model

/* test/mrc_reset_ctrl_tb.sv */
`include "mrc_defines.svh"
module mrc_reset_ctrl_tb import mrc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // short counts keep the run small
    localparam int RSTD = 50;
    localparam int LVQ = 8;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic wdt_timeout = 1'b0;
    logic sleep_or_idle = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hrdata, rd;
    logic hready, hreadyout, hresp, ext_reset_pin_n, shared_port_bit_in, supply_low;
    logic core_reset, pc_clear, sp_to_top, ports_preset, irq_disable, timers_off;
    logic wdt_clear, wdt_timeout_flag, power_down_flag, irq;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    logic lng;
    assign hready = hreadyout;
    always #5 clock = ~clock;
    mrc_reset_ctrl #(.RSTD_CYC(RSTD), .LVQ_CYC(LVQ)) u_mrc_reset_ctrl (.clock(clock), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_reset_pin_n(ext_reset_pin_n), .shared_port_bit_in(shared_port_bit_in), .supply_low(supply_low),
        .wdt_timeout(wdt_timeout), .sleep_or_idle(sleep_or_idle), .core_reset(core_reset),
        .pc_clear(pc_clear), .sp_to_top(sp_to_top), .ports_preset(ports_preset), .irq_disable(irq_disable),
        .timers_off(timers_off), .wdt_clear(wdt_clear), .wdt_timeout_flag(wdt_timeout_flag),
        .power_down_flag(power_down_flag), .irq(irq));
    mrc_pin_supply_model u_mrc_pin_supply_model (.clock(clock), .ext_reset_pin_n(ext_reset_pin_n),
        .supply_low(supply_low));
    function automatic int exp_sst(input mrc_clksel_t s);
        case (s)
            MRC_CK_HXT: return `MRC_SST_XT;
            MRC_CK_SLOW_INTERNAL_RC: return `MRC_SST_LRC;
            default: return `MRC_SST_RC;
        endcase
    endfunction : exp_sst
    task automatic wrap_up();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int v, input int lo, input int hi, input string what);
        total_checks++;
        if (v < lo || v > hi) begin
            fail_count++;
            $display("ERROR %0t %s count %0d", $time, what, v);
        end
    endtask : chk_rng
    task automatic nclk(input int k);
        repeat (k) @(negedge clock);
    endtask : nclk
    // counts cycles until the core leaves reset; bounded so a stuck reset cannot hang
    task automatic meas(output int k);
        k = 0;
        while (core_reset === 1'b1 && k < 5000) begin
            @(negedge clock);
            k++;
        end
    endtask : meas
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wdt_pulse();
        @(posedge clock);
        wdt_timeout <= 1'b1;
        @(posedge clock);
        wdt_timeout <= 1'b0;
    endtask : wdt_pulse
    task automatic por();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (6) @(posedge clock);
        @(negedge clock);
        chk({core_reset, pc_clear, sp_to_top, ports_preset, irq_disable, timers_off, wdt_clear,
            wdt_timeout_flag, power_down_flag, irq}, 32'h3f8, "por outputs");
        @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        meas(n);
        chk_rng(n, RSTD, RSTD + 4, "power-on delay");
        chk({ports_preset, irq_disable, timers_off, wdt_clear}, 32'h0, "released outputs");
    endtask : por
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("ERROR %0t timeout", $time);
            wrap_up();
        end
    end
    initial begin
        void'($urandom(82602));
        por();
        bus(1'b0, `MRC_OFF_CTRL, 32'h0);
        chk(rd, `MRC_CTRL_RST, "ctrl reset value");
        bus(1'b1, 12'h100, 32'hffff_ffff);
        bus(1'b0, 12'h100, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        chk({hreadyout, hresp}, 32'h2, "bus okay response");
        bus(1'b1, `MRC_OFF_IRQS, 32'hf);
        bus(1'b1, `MRC_OFF_IRQM, 32'h0);
        wdt_pulse();
        nclk(3);
        chk({core_reset, ports_preset}, 32'h3, "wdt normal reset");
        meas(n);
        chk({wdt_timeout_flag, power_down_flag}, 32'h2, "flags wdt normal");
        u_mrc_pin_supply_model.pin_low(10);
        chk({core_reset, pc_clear, ports_preset}, 32'h7, "pin reset active");
        meas(n);
        chk_rng(n, RSTD, RSTD + 5, "pin release delay");
        chk({wdt_timeout_flag, power_down_flag}, 32'h2, "flags pin");
        bus(1'b0, `MRC_OFF_IRQS, 32'h0);
        chk(rd, 32'h5, "irq status");
        nclk(2);
        chk(irq, 32'h0, "masked irq");
        bus(1'b1, `MRC_OFF_IRQM, 32'h1);
        nclk(2);
        chk(irq, 32'h1, "unmasked irq");
        bus(1'b1, `MRC_OFF_IRQS, 32'h1);
        nclk(2);
        chk(irq, 32'h0, "irq cleared");
        bus(1'b1, `MRC_OFF_IRQS, 32'h4);
        bus(1'b1, `MRC_OFF_CTRL, 32'h2);
        fork
            u_mrc_pin_supply_model.pin_low(8);
            begin
                nclk(6);
                chk({shared_port_bit_in, core_reset}, 32'h0, "pin as port bit");
            end
        join
        nclk(4);
        chk(shared_port_bit_in, 32'h1, "port bit high");
        bus(1'b1, `MRC_OFF_CTRL, 32'h3);
        // random dips, either clearly short or clearly qualified
        for (int i = 0; i < 6; i++) begin
            // first two dips are fixed corners: one qualified, one short
            lng = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom_range(0, 1));
            u_mrc_pin_supply_model.dip(lng ? $urandom_range(LVQ + 4, 20) : $urandom_range(1, LVQ - 4));
            nclk(3);
            chk(core_reset, {31'h0, lng}, "low supply qualify");
            meas(n);
        end
        chk({wdt_timeout_flag, power_down_flag}, 32'h2, "flags lvr");
        bus(1'b0, `MRC_OFF_STAT, 32'h0);
        chk(rd, {28'h0, 2'(MRC_S_RUN), 2'b10}, "status register");
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, `MRC_OFF_CTRL, {26'h0, 2'h0, 2'(s), 2'h3});
            sleep_or_idle <= 1'b1;
            wdt_pulse();
            nclk(2);
            chk({pc_clear, sp_to_top, ports_preset}, 32'h6, "sleep wake partial");
            meas(n);
            chk_rng(n, exp_sst(mrc_clksel_t'(s)) - 1, exp_sst(mrc_clksel_t'(s)) + 2, "startup count");
            chk({wdt_timeout_flag, power_down_flag}, 32'h3, "flags sleep");
            @(posedge clock);
            sleep_or_idle <= 1'b0;
        end
        bus(1'b0, `MRC_OFF_IRQS, 32'h0);
        chk(rd, 32'ha, "irq status lvr and sleep");
        por();
        bus(1'b0, `MRC_OFF_CTRL, 32'h0);
        chk(rd, `MRC_CTRL_RST, "ctrl after second por");
        wrap_up();
    end
endmodule : mrc_reset_ctrl_tb
